// ### bench/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
  parameter int ERASE_CYC = 40,
  parameter logic [15:0] ARRAY_WORD = 16'h3C5A
) (
  // Clock for erase timing only
  input wire logic i_mclk,
  // Fault to inject: 1 erase, 2 supply, 3 protect, 4 sequence
  input wire logic [2:0] i_fault,
  // Flash pins
  input wire logic [flash_erase_pkg::FA_W-1:0] i_fa,
  input wire logic [flash_erase_pkg::DQ_W-1:0] i_dq,
  input wire logic i_dq_oe,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [flash_erase_pkg::DQ_W-1:0] o_dq
);
  import flash_erase_pkg::*;
  logic [7:0] sr_ff = STATUS_RESET;
  logic status_mode_ff = 1'b0;
  logic [7:0] setup_ff = 8'h00;
  logic [7:0] erased_ff = 8'h00;
  logic [FA_W-1:0] confirm_addr_ff = '0;
  logic [15:0] last_ff = 16'h0000;
  logic [15:0] drv;
  int busy_ff = 0;
  int bad_cmd_ff = 0;
  ////////////////////////////////////////////////////////////////
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_dq_oe) begin
      if (i_dq[15:8] !== 8'h00) bad_cmd_ff++;
      case (i_dq[7:0])
        CMD_READ_ARRAY: status_mode_ff = 1'b0;
        CMD_READ_STATUS: status_mode_ff = 1'b1;
        CMD_CLEAR_STATUS: sr_ff[5:1] = 5'h00;
        CMD_BLOCK_SETUP, CMD_CHIP_SETUP: begin
          setup_ff = i_dq[7:0];
          status_mode_ff = 1'b1;
        end
        CMD_CONFIRM: begin
          erased_ff = setup_ff;
          confirm_addr_ff = i_fa;
          if (setup_ff == 8'h00 || i_fault == 3'd4) sr_ff[5:4] = 2'b11;
          else begin
            sr_ff[7] = 1'b0;
            busy_ff = ERASE_CYC;
          end
          setup_ff = 8'h00;
        end
        default: ;
      endcase
    end
  end
  // Flags only ever OR in, so faults pile up until cleared
  // Non-blocking, so the host never races the ready change at its sample edge
  always @(posedge i_mclk) begin
    if (busy_ff > 0) begin
      busy_ff <= busy_ff - 1;
      if (busy_ff == 1) begin
        if (i_fault == 3'd1) sr_ff[5] <= 1'b1;
        if (i_fault == 3'd2) sr_ff[3] <= 1'b1;
        if (i_fault == 3'd3 && erased_ff == CMD_CHIP_SETUP) sr_ff[1] <= 1'b1;
        sr_ff[7] <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // No pull on the bus: a released line shows the last driven word inverted, not the old data
  assign drv = status_mode_ff ? {8'h00, sr_ff} : ARRAY_WORD;
  assign o_dq = (!i_ce_n && !i_oe_n) ? drv : ~last_ff;
  always @(posedge i_oe_n) last_ff = drv;
endmodule

// ### bench/tb_flash_erase_host.sv
`timescale 1ns/100ps
module tb_flash_erase_host;
  import flash_erase_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} note_t;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic o_pready, o_pslverr, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
  logic [FA_W-1:0] o_fa, blk;
  logic [DQ_W-1:0] o_dq_out, dq_in;
  logic [2:0] fault = 3'd0;
  logic [7:0] bytes [4] = '{8'hA0, 8'h88, 8'h82, 8'hB0};
  note_t notes [$];
  note_t n;
  int errors = 0, checked = 0;
  initial forever #10 i_mclk = ~i_mclk;
  flash_erase_host uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_fa(o_fa),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq(dq_in), .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n), .o_we_n(o_we_n));
  flash_dev_model dev (.i_mclk(i_mclk), .i_fault(fault), .i_fa(o_fa), .i_dq(o_dq_out),
    .i_dq_oe(o_dq_oe), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(dq_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] stat_word(input logic [7:0] b);
    return {11'h0, b[7], b[1], b[3], b[5] & ~b[4], b[5] & b[4], b, 8'h00};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    notes.push_back('{e, m, err});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    notes.push_back('{32'h0, 32'h0, err});
    apb(1'b1, a, d);
  endtask
  // Busy clears when the sequencer is back in S_IDLE, after the closing array command of an erase unless keep is set
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(STATUS_OFS, 32'h0, 32'h0, 1'b0);
      k++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && k < 200);
    if (q[STAT_BUSY_BIT] !== 1'b0) begin
      errors++;
      $display("CHECK FAILED busy expected 0 seen %b", q[STAT_BUSY_BIT]);
      report_and_stop();
    end
  endtask
  task automatic wait_mode(input logic m);
    int k;
    k = 0;
    while (dev.status_mode_ff !== m && k < 100) begin
      @(posedge i_mclk);
      k++;
    end
    if (dev.status_mode_ff !== m) begin
      errors++;
      $display("CHECK FAILED mode expected %b seen %b", m, dev.status_mode_ff);
      report_and_stop();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      n = notes.pop_front();
      checked++;
      if ((o_prdata & n.mask) !== (n.exp & n.mask) || o_pslverr !== n.err) begin
        errors++;
        $display("CHECK FAILED apb %h expected %h/%b seen %h/%b", i_paddr, n.exp & n.mask,
                 n.err, o_prdata & n.mask, o_pslverr);
      end
    end
  end
  initial begin
    #600000;
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hD739));
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(STATUS_OFS, stat_word(STATUS_RESET), 32'hFFFF_FFFF, 1'b0);
    rd(CTRL_OFS, 32'h0, 32'h0000_0100, 1'b0);
    rd(12'hFFC, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(12'h0FC, 32'h1, 1'b1);
    $display("test reset done");
    blk = FA_W'($urandom);
    wr(BLKADDR_OFS, 32'(blk), 1'b0);
    wr(CTRL_OFS, 32'h1, 1'b0);
    rd(STATUS_OFS, 32'h1, 32'h1, 1'b0);
    wait_idle();
    rd(STATUS_OFS, stat_word(8'h80), 32'hFFFF_FFFF, 1'b0);
    wait_mode(1'b0);
    chk("setup code", 32'(CMD_BLOCK_SETUP), 32'(dev.erased_ff));
    chk("confirm addr", 32'(blk), 32'(dev.confirm_addr_ff));
    chk("array mode", 32'h0, 32'(dev.status_mode_ff));
    $display("test block erase done");
    wr(CTRL_OFS, 32'h102, 1'b0);
    wait_idle();
    rd(STATUS_OFS, stat_word(8'h80), 32'hFFFF_FFFF, 1'b0);
    rd(CTRL_OFS, 32'h100, 32'h0000_0100, 1'b0);
    chk("setup code", 32'(CMD_CHIP_SETUP), 32'(dev.erased_ff));
    chk("status mode kept", 32'h1, 32'(dev.status_mode_ff));
    wr(CTRL_OFS, 32'h10, 1'b0);
    wait_mode(1'b0);
    chk("array mode", 32'h0, 32'(dev.status_mode_ff));
    $display("test chip erase done");
    for (int k = 0; k < 4; k++) begin
      fault <= 3'(k + 1);
      wr(CTRL_OFS, (k == 2) ? 32'h2 : 32'h1, 1'b0);
      wait_idle();
      rd(STATUS_OFS, stat_word(bytes[k]), 32'hFFFF_FFFF, 1'b0);
      fault <= 3'd0;
      wr(CTRL_OFS, 32'h1, 1'b0);
      rd(STATUS_OFS, stat_word(bytes[k]), 32'hFFFF_FFFF, 1'b0);
      wr(CTRL_OFS, 32'h4, 1'b0);
      wait_idle();
      rd(STATUS_OFS, stat_word(bytes[k]), 32'hFFFF_FFFF, 1'b0);
      wr(CTRL_OFS, 32'h8, 1'b0);
      wait_idle();
      rd(STATUS_OFS, stat_word(8'h80), 32'hFFFF_FFFF, 1'b0);
      $display("test fault %0d done", k + 1);
    end
    chk("command high byte", 32'h0, 32'(dev.bad_cmd_ff));
    report_and_stop();
  end
endmodule

// ### include/flash_erase_pkg.sv
package flash_erase_pkg;
  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BLKADDR_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  // Control fields
  localparam int CTRL_BLOCK_ERASE_BIT = 0;
  localparam int CTRL_CHIP_ERASE_BIT = 1;
  localparam int CTRL_STATUS_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_ARRAY_BIT = 4;
  localparam int CTRL_KEEP_BIT = 8;
  localparam logic CTRL_KEEP_RESET = 1'b0;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BYTE_LSB = 8;
  localparam int STAT_SEQ_ERR_BIT = 16;
  localparam int STAT_ERASE_ERR_BIT = 17;
  localparam int STAT_SUPPLY_BIT = 18;
  localparam int STAT_PROTECT_BIT = 19;
  localparam int STAT_READY_BIT = 20;
  // Device status byte fields
  localparam int READY_FLAG = 7;
  localparam int ERASE_FAIL_FLAG = 5;
  localparam int WRITE_FAIL_FLAG = 4;
  localparam int SUPPLY_LOW_FLAG = 3;
  localparam int PROTECT_FLAG = 1;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // Device command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
  localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  // Widths
  localparam int FA_W = 20;
  localparam int DQ_W = 16;
  // Timing
  localparam int CLK_NS = 20;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 90;
  localparam logic [2:0] WP_CYC = 3'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] ACC_CYC = 3'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ### include/flash_req_if.sv
`timescale 1ns/100ps
interface flash_req_if;
  import flash_erase_pkg::*;
  logic req;
  logic wr;
  logic [FA_W-1:0] addr;
  logic [DQ_W-1:0] wdata;
  logic done;
  logic [DQ_W-1:0] rdata;
  modport host (output req, output wr, output addr, output wdata, input done, input rdata);
  modport cycle (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ### src/flash_bus_cycle.sv
`timescale 1ns/100ps
module flash_bus_cycle (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Request side
  flash_req_if.cycle rq,
  // Flash pins
  output logic [flash_erase_pkg::FA_W-1:0] o_fa,
  output logic [flash_erase_pkg::DQ_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [flash_erase_pkg::DQ_W-1:0] i_dq,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);
  import flash_erase_pkg::*;

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_ACT = 3'b010,
    C_REC = 3'b100
  } cyc_state_t;

  cyc_state_t state_ff;
  logic [2:0] cnt_ff;
  logic wr_ff;
  logic done_ff;
  logic [DQ_W-1:0] rdata_ff;

  assign rq.done = done_ff;
  assign rq.rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= C_IDLE;
      cnt_ff <= 3'h0;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      o_fa <= 20'h00000;
      o_dq_out <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        C_IDLE: begin
          // Done guard keeps a stale request from starting a second cycle
          if (rq.req && !done_ff) begin
            wr_ff <= rq.wr;
            o_fa <= rq.addr;
            o_dq_out <= rq.wdata;
            o_dq_oe <= rq.wr;
            o_ce_n <= 1'b0;
            o_we_n <= !rq.wr;
            o_oe_n <= rq.wr;
            cnt_ff <= (rq.wr ? WP_CYC : ACC_CYC) - 3'h1;
            state_ff <= C_ACT;
          end
        end
        C_ACT: begin
          if (cnt_ff == 3'h0) begin
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            if (!wr_ff) begin
              rdata_ff <= i_dq;
            end
            state_ff <= C_REC;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        C_REC: begin
          // Data held one cycle past the write strobe for hold time
          o_ce_n <= 1'b1;
          o_dq_oe <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= C_IDLE;
        end
      endcase
    end
  end

  write_pulse_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(o_we_n) |-> (!o_we_n && o_dq_oe && !o_ce_n) [*3] ##1 o_we_n)
    else $error("write strobe width wrong");
  read_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_oe_n |-> !o_dq_oe)
    else $error("data driven during read");
endmodule

// ### src/flash_erase_host.sv
`timescale 1ns/100ps
// Overview of operation
// R1 - Device accumulates error flags; host may check after each or a series.
// R2 - After the last erase the host writes FFH to return to array reads.
// R3 - Host writes 70H, then reads status and samples the ready flag.
// R4 - Chip erase is a 30H setup write followed by a D0H confirm write.
// R5 - Erase-fail and write-fail both set means a command sequence error.
// R6 - A failed erase sets only the erase-fail flag.
// R7 - Chip erase with every block locked aborts and sets the protect flag.
// R8 - Error flags stay set until the clear status command.
// R9 - On any error the host clears status before retrying an erase.
// R10 - Low program supply aborts the operation and sets the supply-low flag.
// R11 - Block erase is 20H at any address, then D0H inside the block.
// R12 - During an erase every read returns status until read array.
module flash_erase_host (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Flash pins
  output logic [flash_erase_pkg::FA_W-1:0] o_fa,
  output logic [flash_erase_pkg::DQ_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [flash_erase_pkg::DQ_W-1:0] i_dq,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n
);
  import flash_erase_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_CMD70 = 7'b0000010,
    S_SETUP = 7'b0000100,
    S_CONFIRM = 7'b0001000,
    S_POLL = 7'b0010000,
    S_ARRAY = 7'b0100000,
    S_CLEAR = 7'b1000000
  } host_state_t;

  flash_req_if rq ();

  host_state_t state_ff;
  logic req_ff;
  logic wr_ff;
  logic [FA_W-1:0] addr_ff;
  logic [7:0] wdata_ff;
  logic chip_ff;
  logic erase_ff;
  logic keep_ff;
  logic [FA_W-1:0] blk_addr_ff;
  logic [7:0] stat_ff;
  logic wr_ctrl;
  logic err_lock;

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == CTRL_OFS) || (a == BLKADDR_OFS) || (a == STATUS_OFS);
  endfunction

  assign rq.req = req_ff;
  assign rq.wr = wr_ff;
  assign rq.addr = addr_ff;
  assign rq.wdata = {8'h00, wdata_ff};

  // Any latched error locks out new erases until a clear
  assign err_lock = stat_ff[ERASE_FAIL_FLAG] | stat_ff[WRITE_FAIL_FLAG]
    | stat_ff[SUPPLY_LOW_FLAG] | stat_ff[PROTECT_FLAG]; // R9
  assign wr_ctrl = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////
  // APB slave: access with no wait states, answer prepared in setup
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable) begin
      o_pready <= 1'b1;
      o_pslverr <= !reg_hit(i_paddr);
      o_prdata <= 32'h00000000;
      if (!i_pwrite) begin
        unique case (i_paddr)
          CTRL_OFS: o_prdata[CTRL_KEEP_BIT] <= keep_ff;
          BLKADDR_OFS: o_prdata[FA_W-1:0] <= blk_addr_ff;
          STATUS_OFS: begin
            o_prdata[STAT_BUSY_BIT] <= (state_ff != S_IDLE);
            o_prdata[STAT_BYTE_LSB +: 8] <= stat_ff;
            o_prdata[STAT_SEQ_ERR_BIT] <= stat_ff[ERASE_FAIL_FLAG]
              & stat_ff[WRITE_FAIL_FLAG]; // R5
            o_prdata[STAT_ERASE_ERR_BIT] <= stat_ff[ERASE_FAIL_FLAG]
              & !stat_ff[WRITE_FAIL_FLAG]; // R6
            o_prdata[STAT_SUPPLY_BIT] <= stat_ff[SUPPLY_LOW_FLAG]; // R10
            o_prdata[STAT_PROTECT_BIT] <= stat_ff[PROTECT_FLAG]; // R7
            o_prdata[STAT_READY_BIT] <= stat_ff[READY_FLAG];
          end
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      keep_ff <= CTRL_KEEP_RESET;
      blk_addr_ff <= 20'h00000;
    end else if (i_psel && i_penable && o_pready && i_pwrite) begin
      if (i_paddr == CTRL_OFS) begin
        keep_ff <= i_pwdata[CTRL_KEEP_BIT];
      end
      if (i_paddr == BLKADDR_OFS) begin
        blk_addr_ff <= i_pwdata[FA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: each state except S_IDLE issues one bus cycle and advances on its done, S_POLL only once ready
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= S_IDLE;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= 20'h00000;
      wdata_ff <= 8'h00;
      chip_ff <= 1'b0;
      erase_ff <= 1'b0;
      stat_ff <= STATUS_RESET;
    end else if (req_ff) begin
      if (rq.done) begin
        req_ff <= 1'b0;
        unique case (state_ff)
          S_SETUP: state_ff <= S_CONFIRM;
          // Device answers reads with status while erasing, no 70H needed
          S_CONFIRM: state_ff <= S_POLL; // R12
          S_CMD70: state_ff <= S_POLL; // R3
          S_POLL: begin
            // Flags are sticky in the device, so a copy is always complete
            stat_ff <= rq.rdata[7:0]; // R1
            if (rq.rdata[READY_FLAG]) begin // R3
              state_ff <= (erase_ff && !keep_ff) ? S_ARRAY : S_IDLE; // R2
            end
          end
          S_CLEAR: begin
            stat_ff <= STATUS_RESET; // R8
            state_ff <= S_IDLE;
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          erase_ff <= 1'b0;
          if (wr_ctrl) begin
            if (i_pwdata[CTRL_CLEAR_BIT]) begin
              state_ff <= S_CLEAR;
            end else if ((i_pwdata[CTRL_BLOCK_ERASE_BIT] || i_pwdata[CTRL_CHIP_ERASE_BIT])
                && !err_lock) begin // R9
              chip_ff <= !i_pwdata[CTRL_BLOCK_ERASE_BIT];
              erase_ff <= 1'b1;
              state_ff <= S_SETUP;
            end else if (i_pwdata[CTRL_STATUS_BIT]) begin
              state_ff <= S_CMD70;
            end else if (i_pwdata[CTRL_ARRAY_BIT]) begin
              state_ff <= S_ARRAY;
            end
          end
        end
        S_CMD70: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b1;
          wdata_ff <= CMD_READ_STATUS; // R3
        end
        S_SETUP: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b1;
          addr_ff <= 20'h00000;
          wdata_ff <= chip_ff ? CMD_CHIP_SETUP : CMD_BLOCK_SETUP; // R4 R11
        end
        S_CONFIRM: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b1;
          addr_ff <= blk_addr_ff; // R11
          wdata_ff <= CMD_CONFIRM; // R4
        end
        S_POLL: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b0;
        end
        S_ARRAY: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b1;
          wdata_ff <= CMD_READ_ARRAY; // R2
        end
        S_CLEAR: begin
          req_ff <= 1'b1;
          wr_ff <= 1'b1;
          wdata_ff <= CMD_CLEAR_STATUS; // R9
        end
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .rq(rq),
    .o_fa(o_fa),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe),
    .i_dq(i_dq),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n)
  );

  ////////////////////////////////////////////////////////////////////////
  confirm_addr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R11
    (state_ff == S_CONFIRM && req_ff) |-> (addr_ff == blk_addr_ff && wdata_ff == CMD_CONFIRM))
    else $error("confirm not at block address");
  setup_order_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
    $rose(state_ff == S_CONFIRM) |-> $past(state_ff) == S_SETUP
      && $past(wdata_ff) == (chip_ff ? CMD_CHIP_SETUP : CMD_BLOCK_SETUP))
    else $error("confirm without setup");
  array_code_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
    (state_ff == S_POLL && req_ff && rq.done && rq.rdata[READY_FLAG] && erase_ff && !keep_ff)
      |=> ##1 (state_ff == S_ARRAY && req_ff && wr_ff && wdata_ff == CMD_READ_ARRAY))
    else $error("read array not issued after erase");
  status_poll_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
    (state_ff == S_CMD70 && req_ff && rq.done) |=> state_ff == S_POLL ##1 (req_ff && !wr_ff))
    else $error("status read not after 70H");
  retry_lock_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R9
    (state_ff == S_IDLE && err_lock && !req_ff) |=> state_ff != S_SETUP)
    else $error("erase started with errors latched");
endmodule
